// ### txn_nest_abort_ctl.sv
// transaction nesting, commit/abort decision, abort status word and debug intercept
// assumes the core presents one retiring instruction and its event flags per cycle
// Function
// - hidden nesting counter: begin adds one, end subtracts one
// - commit only when the counter returns to zero; inner ends commit nothing
// - abort when a begin would push nesting past the maximum depth
// - hints inside a transaction are ignored; explicit ops in elided regions abort elision
// - status bit 0 set only for an explicit abort instruction
// - status bit 1 means retry may succeed; forced low when bit 0 set
// - status bit 2 set on a conflict from another logical processor
// - status bit 3 set on transactional buffer overflow
// - status bit 4 set when a debug breakpoint caused the abort
// - status bit 5 set when the abort happened at a nested level
// - bits 31:24 carry the abort argument only with bit 0; others reserved zero
// - status holds causes only and may be all zero
// - commit makes all transactional memory operations atomic with locked ordering
// - begin does not fence; abort discards every transactional memory update
// - default debug abort goes to fallback with state restored and bit 4 set
// - with both debug enables set, roll back before begin and raise debug exception
// - in that mode clear debug status bit 16
// - direction instructions abort only when they change the flag
// - abort, identify and spin-pause instructions always abort
// - fences, timestamp reads and register ops do not abort; vector mixing may
// - implementation-dependent classes may abort; software must not rely on it
// - abort restores state from the outermost begin and resumes at fallback
// - the 8-bit abort argument is loaded into the status register
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module txn_nest_abort_ctl
  import txn_ctl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire instr_type instr_in,
  input wire event_type events_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic commit_out,
  output logic abort_out,
  output logic elide_abort_out,
  output logic redirect_valid_out,
  output logic [DATA_W-1:0] redirect_addr_out,
  output logic debug_exc_out,
  output logic in_txn_out,
  output logic direction_flag_out
);

  function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = strobe && (a == off);
  endfunction : reg_hit

  function automatic logic explicit_op(input op_type op);
    explicit_op = (op == OP_BEGIN) || (op == OP_END) || (op == OP_ABORT);
  endfunction : explicit_op

  txn_state_type state_r;
  logic [DEPTH_W-1:0] depth_r;
  logic [DATA_W-1:0] status_r;
  logic [DATA_W-1:0] saved_status_r;
  logic saved_dir_r;
  logic [DATA_W-1:0] fallback_r;
  logic [DATA_W-1:0] begin_pc_r;
  logic dir_r;
  logic [DATA_W-1:0] dbg_ctrl_r;
  logic [DATA_W-1:0] dbg_model_r;
  logic [DATA_W-1:0] dbg_stat_r;
  logic [2:0] ctrl_r;

  logic in_txn;
  logic elide_abort;
  logic exec;
  logic do_begin;
  logic do_end;
  logic do_set_dir;
  logic do_clr_dir;
  logic hit_explicit;
  logic hit_retry;
  logic hit_debug;
  logic hit_misc;
  logic hit_conflict;
  logic hit_overflow;
  logic close_now;
  logic abort_now;
  logic commit_now;
  logic intercept;
  logic [DATA_W-1:0] abort_word;
  logic [DATA_W-1:0] read_word;

  // qualifiers of the retiring instruction
  always_comb begin
    in_txn = (state_r == ST_TXN);
    elide_abort = 1'b0;
    // explicit ops met inside an elided region drop the elision instead of running
    if (instr_in.valid && events_in.elided_region && ctrl_r[CTRL_ELIDE_ABORT_BIT]) begin
      elide_abort = explicit_op(instr_in.op);
    end
    exec = instr_in.valid && !elide_abort;
    do_begin = exec && (instr_in.op == OP_BEGIN);
    do_end = exec && in_txn && (instr_in.op == OP_END);
    do_set_dir = exec && (instr_in.op == OP_SET_DIR);
    do_clr_dir = exec && (instr_in.op == OP_CLR_DIR);
  end

  // causes carried by the instruction; they only count inside a transaction
  always_comb begin
    hit_explicit = 1'b0;
    hit_misc = 1'b0;
    if (exec && in_txn) begin
      case (instr_in.op)
        OP_BEGIN: hit_misc = (depth_r == MAX_EXPLICIT_NEST_DEPTH);
        OP_ABORT: hit_explicit = 1'b1;
        OP_IDENTIFY: hit_misc = 1'b1;
        OP_PAUSE: hit_misc = 1'b1;
        OP_SET_DIR: hit_misc = !dir_r;
        OP_CLR_DIR: hit_misc = dir_r;
        OP_VEC_MIX: hit_misc = ctrl_r[CTRL_VEC_MIX_BIT];
        OP_IMPL_DEP: hit_misc = ctrl_r[CTRL_IMPL_ABORT_BIT];
        default: hit_misc = 1'b0; // hints, fences and plain ops pass
      endcase
    end
  end

  // causes raised by the core, the abort decision and the debug intercept
  always_comb begin
    hit_conflict = in_txn && events_in.conflict;
    hit_overflow = in_txn && events_in.overflow;
    // a conflict is transient, so a retry may well succeed
    hit_retry = hit_conflict;
    hit_debug = in_txn && (events_in.debug_exc || events_in.breakpoint);
    abort_now = hit_explicit || hit_misc || hit_debug || hit_conflict || hit_overflow;
    commit_now = do_end && !abort_now && (depth_r == DEPTH_ONE);
    close_now = abort_now || commit_now;
    // both enables must be set; either alone keeps the default fallback path
    intercept = hit_debug && dbg_ctrl_r[DBG_CTRL_EN_BIT] &&
                dbg_model_r[DBG_MODEL_EN_BIT];
  end

  // abort status word; reserved bits stay zero
  always_comb begin
    abort_word = WORD_ZERO;
    abort_word[ST_EXPLICIT_BIT] = hit_explicit;
    abort_word[ST_RETRY_BIT] = hit_retry && !hit_explicit;
    // several causes in one cycle set several bits
    abort_word[ST_CONFLICT_BIT] = hit_conflict;
    abort_word[ST_OVERFLOW_BIT] = hit_overflow;
    abort_word[ST_DEBUG_BIT] = hit_debug;
    abort_word[ST_NESTED_BIT] = (depth_r > DEPTH_ONE);
    if (hit_explicit) begin
      abort_word[ST_ARG_MSB:ST_ARG_LSB] = instr_in.imm;
    end
  end

  // open or closed state; the counter itself is never readable
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_IDLE;
    end else if (close_now) begin
      state_r <= ST_IDLE;
    end else if (do_begin) begin
      state_r <= ST_TXN;
    end
  end

  // hidden nesting depth; a stray end outside a transaction leaves it at zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      depth_r <= DEPTH_ZERO;
    end else if (close_now) begin
      depth_r <= DEPTH_ZERO;
    end else if (do_begin) begin
      depth_r <= depth_r + DEPTH_ONE;
    end else if (do_end) begin
      depth_r <= depth_r - DEPTH_ONE;
    end
  end

  // registered copy of the open state for the core
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      in_txn_out <= 1'b0;
    end else if (close_now) begin
      in_txn_out <= 1'b0;
    end else if (do_begin) begin
      in_txn_out <= 1'b1;
    end
  end

  // snapshot at the outermost begin for the intercept rollback
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      saved_status_r <= STATUS_RST;
      begin_pc_r <= WORD_ZERO;
    end else if (do_begin && !in_txn) begin
      saved_status_r <= status_r;
      begin_pc_r <= instr_in.pc;
    end
  end

  // snapshot at the outermost begin for the default abort path
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      saved_dir_r <= 1'b0;
      fallback_r <= WORD_ZERO;
    end else if (do_begin && !in_txn) begin
      saved_dir_r <= dir_r;
      fallback_r <= instr_in.fallback;
    end
  end

  // direction flag is architectural and rolls back with the transaction
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dir_r <= 1'b0;
    end else if (abort_now) begin
      dir_r <= saved_dir_r;
    end else if (do_set_dir) begin
      dir_r <= 1'b1;
    end else if (do_clr_dir) begin
      dir_r <= 1'b0;
    end
  end

  // status register: an abort in the same cycle beats a software write
  // software may preload it; the intercept path puts that value back
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_r <= STATUS_RST;
    end else if (abort_now) begin
      status_r <= intercept ? saved_status_r : abort_word;
    end else if (reg_hit(wr_in, addr_in, STATUS_OFF)) begin
      status_r <= wdata_in;
    end
  end

  // debug control enable word
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dbg_ctrl_r <= DBG_CTRL_RST;
    end else if (reg_hit(wr_in, addr_in, DBG_CTRL_OFF)) begin
      dbg_ctrl_r <= wdata_in;
    end
  end

  // debug control model enable word
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dbg_model_r <= DBG_MODEL_RST;
    end else if (reg_hit(wr_in, addr_in, DBG_MODEL_OFF)) begin
      dbg_model_r <= wdata_in;
    end
  end

  // software control bits; only the low field is stored, the rest reads zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= CTRL_RST;
    end else if (reg_hit(wr_in, addr_in, CTRL_OFF)) begin
      ctrl_r <= wdata_in[CTRL_ELIDE_ABORT_BIT:CTRL_IMPL_ABORT_BIT];
    end
  end

  // debug status: the hardware clear wins over a same-cycle software write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dbg_stat_r <= DBG_STAT_RST;
    end else begin
      if (reg_hit(wr_in, addr_in, DBG_STAT_OFF)) begin
        dbg_stat_r <= wdata_in;
      end
      if (abort_now && intercept) begin
        dbg_stat_r[DBG_STAT_TXN_BIT] <= 1'b0;
      end
    end
  end

  // commit publishes the write set at once with locked ordering
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      commit_out <= 1'b0;
    end else begin
      commit_out <= commit_now;
    end
  end

  // abort tells the memory side to drop the write set
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      abort_out <= 1'b0;
    end else begin
      abort_out <= abort_now;
    end
  end

  // elision dropped, so the core re-runs the region without it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      elide_abort_out <= 1'b0;
    end else begin
      elide_abort_out <= elide_abort;
    end
  end

  // fetch redirect pulse rides with the abort pulse
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      redirect_valid_out <= 1'b0;
    end else begin
      redirect_valid_out <= abort_now;
    end
  end

  // redirect target holds until the next abort
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      redirect_addr_out <= WORD_ZERO;
    end else if (abort_now) begin
      redirect_addr_out <= intercept ? begin_pc_r : fallback_r;
    end
  end

  // debug exception only in the intercept mode
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      debug_exc_out <= 1'b0;
    end else begin
      debug_exc_out <= abort_now && intercept;
    end
  end

  // read mux; unmapped offsets read zero and the depth has no offset at all
  always_comb begin
    read_word = WORD_ZERO;
    case (addr_in)
      STATUS_OFF: read_word = status_r;
      DBG_CTRL_OFF: read_word = dbg_ctrl_r;
      DBG_MODEL_OFF: read_word = dbg_model_r;
      DBG_STAT_OFF: read_word = dbg_stat_r;
      CTRL_OFF: read_word[CTRL_ELIDE_ABORT_BIT:CTRL_IMPL_ABORT_BIT] = ctrl_r;
      STATE_OFF: begin
        read_word[STATE_TXN_BIT] = in_txn;
        read_word[STATE_DIR_BIT] = dir_r;
      end
      default: read_word = WORD_ZERO;
    endcase
  end

  // read data valid only the cycle after the strobe, zero otherwise
  // the master never waits: every read answers on the next edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= WORD_ZERO;
    end else begin
      rdata_out <= rd_in ? read_word : WORD_ZERO;
    end
  end

  // pin copy of the direction flag, kept apart so the output comes from a flop
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      direction_flag_out <= 1'b0;
    end else if (abort_now) begin
      direction_flag_out <= saved_dir_r;
    end else if (do_set_dir) begin
      direction_flag_out <= 1'b1;
    end else if (do_clr_dir) begin
      direction_flag_out <= 1'b0;
    end
  end

endmodule : txn_nest_abort_ctl

// ### txn_ctl_pkg.sv
// constants, register map and carrier types for the transaction nest and abort control
// assumes one core clock; all inputs come from core logic on that clock
package txn_ctl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DEPTH_W = 4;
  // maximum explicit nesting depth; value is implementation defined
  localparam logic [DEPTH_W-1:0] MAX_EXPLICIT_NEST_DEPTH = 4'h7;
  localparam logic [DEPTH_W-1:0] DEPTH_ZERO = 4'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;
  // register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] DBG_CTRL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] DBG_MODEL_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] DBG_STAT_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] STATE_OFF = 8'h14;
  // abort status word layout
  localparam int unsigned ST_EXPLICIT_BIT = 0;
  localparam int unsigned ST_RETRY_BIT = 1;
  localparam int unsigned ST_CONFLICT_BIT = 2;
  localparam int unsigned ST_OVERFLOW_BIT = 3;
  localparam int unsigned ST_DEBUG_BIT = 4;
  localparam int unsigned ST_NESTED_BIT = 5;
  localparam int unsigned ST_ARG_LSB = 24;
  localparam int unsigned ST_ARG_MSB = 31;
  // debug enables and debug status flag
  localparam int unsigned DBG_CTRL_EN_BIT = 11;
  localparam int unsigned DBG_MODEL_EN_BIT = 15;
  localparam int unsigned DBG_STAT_TXN_BIT = 16;
  // control register bits
  localparam int unsigned CTRL_IMPL_ABORT_BIT = 0;
  localparam int unsigned CTRL_VEC_MIX_BIT = 1;
  localparam int unsigned CTRL_ELIDE_ABORT_BIT = 2;
  // state register bits
  localparam int unsigned STATE_TXN_BIT = 0;
  localparam int unsigned STATE_DIR_BIT = 1;
  // reset values
  localparam logic [DATA_W-1:0] STATUS_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DBG_CTRL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DBG_MODEL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DBG_STAT_RST = 32'h0001_0000;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_OTHER = 4'h0,
    OP_BEGIN = 4'h1,
    OP_END = 4'h2,
    OP_ABORT = 4'h3,
    OP_IDENTIFY = 4'h4,
    OP_PAUSE = 4'h5,
    OP_SET_DIR = 4'h6,
    OP_CLR_DIR = 4'h7,
    OP_SAFE = 4'h8,
    OP_VEC_MIX = 4'h9,
    OP_IMPL_DEP = 4'ha,
    OP_ELISION_HINT = 4'hb
  } op_type;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_TXN = 1'b1
  } txn_state_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic [7:0] imm;
    logic [DATA_W-1:0] pc;
    logic [DATA_W-1:0] fallback;
  } instr_type;

  typedef struct packed {
    logic conflict;
    logic overflow;
    logic debug_exc;
    logic breakpoint;
    logic elided_region;
  } event_type;
endpackage : txn_ctl_pkg

// ### txn_ctl_checker.sv
// port checker for the transaction nest and abort control
// assumes one core clock and the active-low async reset of the block
`timescale 1ns/1ps
module txn_ctl_checker
  import txn_ctl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire instr_type instr_in,
  input wire event_type events_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic commit_out,
  input wire logic abort_out,
  input wire logic redirect_valid_out,
  input wire logic in_txn_out,
  input wire logic direction_flag_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_idle_begin;
    !in_txn_out ##0 (instr_in.valid && instr_in.op == OP_BEGIN && !events_in.elided_region);
  endsequence
  sequence s_forced;
    in_txn_out ##0 (instr_in.valid && !events_in.elided_region &&
                    instr_in.op inside {OP_ABORT, OP_IDENTIFY, OP_PAUSE});
  endsequence
  a_begin_opens: assert property (s_idle_begin |=> in_txn_out && !abort_out)
    else $error("begin from idle did not open a transaction");
  a_forced_abort: assert property (s_forced |=> abort_out)
    else $error("always-abort instruction did not abort");
  a_commit_cause: assert property (commit_out |-> $past(instr_in.valid && instr_in.op == OP_END && in_txn_out))
    else $error("commit without an end inside a transaction");
  a_no_both: assert property (!(commit_out && abort_out))
    else $error("commit and abort together");
  a_redirect_pair: assert property (redirect_valid_out == abort_out)
    else $error("redirect not paired with abort");
  a_abort_closes: assert property (abort_out |-> !in_txn_out)
    else $error("transaction still open after abort");
  // outside a transaction only a begin may open one; nothing commits or aborts
  a_idle_quiet: assert property (!in_txn_out && !(instr_in.valid && instr_in.op == OP_BEGIN)
    |=> !commit_out && !abort_out && !in_txn_out)
    else $error("activity while idle");
  a_same_dir_safe: assert property (in_txn_out && instr_in.valid && instr_in.op == OP_SET_DIR
    && direction_flag_out && events_in == '0 |=> !abort_out)
    else $error("unchanged direction flag aborted");
  a_read_window: assert property (!rd_in |=> rdata_out == '0)
    else $error("read data outside its cycle");
endmodule : txn_ctl_checker

bind txn_nest_abort_ctl txn_ctl_checker u_checker (
  .clk_in(clk_in), .rstn_in(rstn_in), .instr_in(instr_in), .events_in(events_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .commit_out(commit_out), .abort_out(abort_out),
  .redirect_valid_out(redirect_valid_out), .in_txn_out(in_txn_out),
  .direction_flag_out(direction_flag_out));

// ### testbench.sv
// self-checking bench for the transaction nest and abort control
// drives instructions, events and register strobes itself
`timescale 1ns/1ps
module testbench;
  import txn_ctl_pkg::*;
  localparam logic [DATA_W-1:0] PC_B = 32'h0000_1000;
  localparam logic [DATA_W-1:0] FB = 32'h0000_2000;
  localparam event_type E0 = 5'h00;
  localparam event_type E_CF = 5'h10;
  localparam event_type E_OV = 5'h08;
  localparam event_type E_DB = 5'h04;
  localparam event_type E_BP = 5'h02;
  localparam event_type E_EL = 5'h01;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  instr_type instr_in = '0;
  event_type events_in = '0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [DATA_W-1:0] rdata_out;
  logic [DATA_W-1:0] redir_a;
  logic commit_out, abort_out, redir_v, dbg_exc, in_txn, dir_f, elide_o;
  int err_total = 0;
  int n_compared = 0;
  op_type forced [2] = '{OP_IDENTIFY, OP_PAUSE};
  always #25 clk_in = ~clk_in;
  txn_nest_abort_ctl uut (.clk_in(clk_in), .rstn_in(rstn_in), .instr_in(instr_in),
    .events_in(events_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .commit_out(commit_out), .abort_out(abort_out),
    .elide_abort_out(elide_o), .redirect_valid_out(redir_v), .redirect_addr_out(redir_a),
    .debug_exc_out(dbg_exc), .in_txn_out(in_txn), .direction_flag_out(dir_f));
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one instruction or event, outputs looked at just after the sampling edge
  task automatic step(input op_type op, input logic [7:0] imm, input event_type ev);
    @(posedge clk_in);
    instr_in <= '{op != OP_OTHER, op, imm, PC_B, FB};
    events_in <= ev;
    @(posedge clk_in);
    instr_in.valid <= 1'b0;
    events_in <= E0;
    #1;
  endtask : step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, rdata_out, e);
  endtask : rd
  initial begin
    repeat (4000) @(posedge clk_in);
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd("status", STATUS_OFF, STATUS_RST);
    rd("dbg ctrl", DBG_CTRL_OFF, DBG_CTRL_RST);
    rd("dbg model", DBG_MODEL_OFF, DBG_MODEL_RST);
    rd("dbg status", DBG_STAT_OFF, DBG_STAT_RST);
    rd("ctrl", CTRL_OFF, 32'h0000_0000);
    rd("unmapped", 8'hfc, 32'h0000_0000);
    step(OP_BEGIN, 8'h00, E0);
    chk("in txn", in_txn, 1);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_END, 8'h00, E0);
    chk("inner commit", commit_out, 0);
    chk("still in txn", in_txn, 1);
    step(OP_END, 8'h00, E0);
    chk("outer commit", commit_out, 1);
    step(OP_END, 8'h00, E0);
    chk("stray end", commit_out, 0);
    // explicit abort with a conflict in the same cycle: retry must stay low
    step(OP_BEGIN, 8'h00, E0);
    step(OP_ABORT, 8'h5a, E_CF);
    chk("abort", abort_out, 1);
    chk("redirect valid", redir_v, 1);
    chk("redirect addr", redir_a, FB);
    rd("explicit status", STATUS_OFF, 32'h5a00_0005);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_OTHER, 8'h00, E_CF);
    chk("conflict abort", abort_out, 1);
    rd("conflict status", STATUS_OFF, 32'h0000_0026);
    step(OP_END, 8'h00, E0);
    chk("end after abort", commit_out, 0);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_OTHER, 8'h00, E_OV);
    chk("overflow abort", abort_out, 1);
    rd("overflow status", STATUS_OFF, 32'h0000_0008);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_OTHER, 8'h00, E_BP);
    chk("debug fallback", redir_a, FB);
    chk("no debug exc", dbg_exc, 0);
    rd("debug status", STATUS_OFF, 32'h0000_0010);
    repeat (7) step(OP_BEGIN, 8'h00, E0);
    chk("depth max ok", abort_out, 0);
    step(OP_BEGIN, 8'h00, E0);
    chk("depth overflow", abort_out, 1);
    rd("depth status", STATUS_OFF, 32'h0000_0020);
    foreach (forced[i]) begin
      step(OP_BEGIN, 8'h00, E0);
      step(forced[i], 8'h00, E0);
      chk("forced abort", abort_out, 1);
      rd("forced status", STATUS_OFF, 32'h0000_0000);
    end
    step(OP_BEGIN, 8'h00, E0);
    step(OP_SAFE, 8'h00, E0);
    chk("safe op", abort_out, 0);
    step(OP_END, 8'h00, E0);
    chk("safe commit", commit_out, 1);
    step(OP_SET_DIR, 8'h00, E0);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_SET_DIR, 8'h00, E0);
    chk("same dir", abort_out, 0);
    step(OP_CLR_DIR, 8'h00, E0);
    chk("dir change", abort_out, 1);
    chk("dir restored", dir_f, 1);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_ELISION_HINT, 8'h00, E0);
    chk("hint ignored", abort_out, 0);
    step(OP_VEC_MIX, 8'h00, E0);
    chk("vec mix off", abort_out, 0);
    step(OP_IMPL_DEP, 8'h00, E0);
    chk("impl dep off", abort_out, 0);
    rd("state open", STATE_OFF, 32'h0000_0003);
    wr(CTRL_OFF, 32'h0000_0007);
    rd("ctrl set", CTRL_OFF, 32'h0000_0007);
    step(OP_VEC_MIX, 8'h00, E0);
    chk("vec mix on", abort_out, 1);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_IMPL_DEP, 8'h00, E0);
    chk("impl dep on", abort_out, 1);
    rd("state closed", STATE_OFF, 32'h0000_0002);
    step(OP_BEGIN, 8'h00, E_EL);
    chk("elided begin", elide_o, 1);
    chk("elided no txn", in_txn, 0);
    // debugger intercept: both enables set, status must come back as written
    wr(DBG_CTRL_OFF, 32'h0000_0800);
    wr(DBG_MODEL_OFF, 32'h0000_8000);
    wr(STATUS_OFF, 32'h0000_00aa);
    step(OP_BEGIN, 8'h00, E0);
    step(OP_OTHER, 8'h00, E_DB);
    chk("debug exc", dbg_exc, 1);
    chk("rollback addr", redir_a, PC_B);
    rd("status restored", STATUS_OFF, 32'h0000_00aa);
    rd("dbg status clr", DBG_STAT_OFF, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : testbench
